//--- include/dph_pkg.sv
// package: constants and state codes for the parallel handshake host port
package dph_pkg;

	localparam int         CLK_PERIOD_NS = 10;
	// bus setup before the strobe falls, bus hold after it rises
	localparam int         T_SETUP_NS    = 20;
	localparam int         T_HOLD_NS     = 20;
	localparam int         CNT_W         = 4;
	localparam logic [CNT_W-1:0] SETUP_CYC =
		CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC  =
		CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

	localparam int         BUS_W         = 8;
	localparam logic [7:0] XON_CHAR      = 8'h11;
	localparam logic [7:0] XOFF_CHAR     = 8'h13;
	localparam logic [7:0] BUS_RST       = 8'h00;
	// handshake pins idle high
	localparam logic [2:0] PIN_IDLE      = 3'h7;

	typedef enum logic [1:0]
	{
		C_IDLE  = 2'b00,
		C_READY = 2'b01,
		C_DONE  = 2'b11
	} dph_cmd_st_t;

	typedef enum logic [2:0]
	{
		D_IDLE   = 3'b000,
		D_WAIT   = 3'b001,
		D_SETUP  = 3'b011,
		D_STROBE = 3'b010,
		D_HOLD   = 3'b110
	} dph_dat_st_t;

endpackage : dph_pkg

//--- rtl/dph_sync.sv
// two-flop synchroniser for pins, with a chosen reset level
`timescale 1ns/1ns
module dph_sync
#(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
)
(
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_ff;

	// the first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_ff <= RST_VAL;
			o_q     <= RST_VAL;
		end
		else
		begin
			meta_ff <= i_d;
			o_q     <= meta_ff;
		end
	end

endmodule : dph_sync

//--- rtl/dph_port.sv
// parallel handshake port: command bytes in, message bytes out
`timescale 1ns/1ns
module dph_port
	import dph_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_io_port_select,
	input  wire logic             i_cmd_pending_n,
	input  wire logic             i_host_rx_ready_n,
	input  wire logic [BUS_W-1:0] i_port_bus_in,
	input  wire logic             i_cmd_ready,
	input  wire logic             i_tx_valid,
	input  wire logic [BUS_W-1:0] i_tx_data,
	input  wire logic             i_tx_last,
	output logic      [BUS_W-1:0] o_port_bus_out,
	output logic                  o_port_bus_oe,
	output logic                  o_cmd_accept_n,
	output logic                  o_out_strobe_n,
	output logic                  o_msg_request_n,
	output logic                  o_xcvr_drive_en,
	output logic                  o_xcvr_dir,
	output logic                  o_serial_sel,
	output logic      [BUS_W-1:0] o_cmd_byte,
	output logic                  o_cmd_valid,
	output logic                  o_tx_ready,
	output logic                  o_xoff_paused
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		dph_cmd_st_t      cst;
		dph_dat_st_t      dst;
		logic [BUS_W-1:0] cmd;
		logic             cmd_vld;
		logic [BUS_W-1:0] dout;
		logic             last;
		logic             oe;
		logic             accept_n;
		logic             strobe_n;
		logic             req_n;
		logic             xoff;
		logic             tx_rdy;
		logic             par;
		logic             ser;
		logic [CNT_W-1:0] cnt;
	} dph_state_t;

	dph_state_t       st_ff;
	dph_state_t       nxt_st;
	logic [2:0]       pins_s;
	logic [BUS_W-1:0] bus_s;
	logic             par_s;
	logic             pend_s;
	logic             hrdy_s;

	////////////////////////////////////////////////////////////////////////
	// pins come from the host's domain
	dph_sync #(.W(3), .RST_VAL(PIN_IDLE)) u_sync_ctl
	(
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    ({i_io_port_select, i_cmd_pending_n, i_host_rx_ready_n}),
		.o_q    (pins_s)
	);

	// the bus settles before cmd_pending_n rises, so same-depth sync is safe
	dph_sync #(.W(BUS_W), .RST_VAL(BUS_RST)) u_sync_bus
	(
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    (i_port_bus_in),
		.o_q    (bus_s)
	);

	assign par_s  = pins_s[2];
	assign pend_s = pins_s[1];
	assign hrdy_s = pins_s[0];

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_st         = st_ff;
		nxt_st.cmd_vld = 1'b0;
		nxt_st.tx_rdy  = 1'b0;
		nxt_st.par     = par_s;
		// kept as its own flop so the output needs no gate after the register
		nxt_st.ser     = ~par_s;

		unique case (st_ff.cst)
			C_IDLE:
			begin
				if (st_ff.par && !pend_s && i_cmd_ready)
				begin
					nxt_st.accept_n = 1'b0;
					nxt_st.cst      = C_READY;
				end
			end
			C_READY:
			begin
				if (pend_s)
				begin
					nxt_st.cmd      = bus_s;
					nxt_st.accept_n = 1'b1;
					nxt_st.cst      = C_DONE;
					// pacing characters are consumed here, not passed on
					if (bus_s == XOFF_CHAR)
						nxt_st.xoff = 1'b1;
					else if (bus_s == XON_CHAR)
						nxt_st.xoff = 1'b0;
					else
						nxt_st.cmd_vld = 1'b1;
				end
			end
			C_DONE:
				nxt_st.cst = C_IDLE;
			default:
				nxt_st.cst = C_IDLE;
		endcase

		unique case (st_ff.dst)
			D_IDLE:
			begin
				if (st_ff.par && i_tx_valid && !st_ff.xoff)
				begin
					nxt_st.req_n = 1'b0;
					nxt_st.dst   = D_WAIT;
				end
			end
			D_WAIT:
			begin
				// xoff only stops output between bytes, never mid-cycle
				if (!hrdy_s && !st_ff.xoff && i_tx_valid)
				begin
					nxt_st.dout   = i_tx_data;
					nxt_st.last   = i_tx_last;
					nxt_st.oe     = 1'b1;
					nxt_st.tx_rdy = 1'b1;
					nxt_st.cnt    = SETUP_CYC;
					nxt_st.dst    = D_SETUP;
				end
			end
			D_SETUP:
			begin
				if (st_ff.cnt > CNT_ONE)
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				else
				begin
					nxt_st.strobe_n = 1'b0;
					nxt_st.dst      = D_STROBE;
				end
			end
			D_STROBE:
			begin
				if (hrdy_s)
				begin
					nxt_st.strobe_n = 1'b1;
					nxt_st.cnt      = HOLD_CYC;
					nxt_st.dst      = D_HOLD;
				end
			end
			D_HOLD:
			begin
				if (st_ff.cnt > CNT_ONE)
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				else
				begin
					nxt_st.oe = 1'b0;
					if (st_ff.last)
					begin
						nxt_st.req_n = 1'b1;
						nxt_st.dst   = D_IDLE;
					end
					else
						nxt_st.dst = D_WAIT;
				end
			end
			default:
				nxt_st.dst = D_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_ff          <= '0;
			st_ff.cst      <= C_IDLE;
			st_ff.dst      <= D_IDLE;
			st_ff.accept_n <= 1'b1;
			st_ff.strobe_n <= 1'b1;
			st_ff.req_n    <= 1'b1;
			st_ff.par      <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////
	assign o_port_bus_out  = st_ff.dout;
	assign o_port_bus_oe   = st_ff.oe;
	assign o_cmd_accept_n  = st_ff.accept_n;
	assign o_out_strobe_n  = st_ff.strobe_n;
	assign o_msg_request_n = st_ff.req_n;
	assign o_xcvr_drive_en = st_ff.par;
	assign o_xcvr_dir      = st_ff.oe;
	assign o_serial_sel    = st_ff.ser;
	assign o_cmd_byte      = st_ff.cmd;
	assign o_cmd_valid     = st_ff.cmd_vld;
	assign o_tx_ready      = st_ff.tx_rdy;
	assign o_xoff_paused   = st_ff.xoff;

	////////////////////////////////////////////////////////////////////////
	chk_accept_on_pend: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_cmd_accept_n) |-> !$past(pend_s) && $past(i_cmd_ready))
		else $error("accept fell without a pending command");

	chk_cmd_capture: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_cmd_accept_n) |-> $past(pend_s)
			&& o_cmd_byte == $past(bus_s))
		else $error("command byte not captured on accept rise");

	chk_req_held: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(o_port_bus_oe || !o_out_strobe_n) |-> !o_msg_request_n)
		else $error("request released during a byte");

	chk_strobe_setup: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_out_strobe_n) |-> $past(o_port_bus_oe, 2)
			&& $stable(o_port_bus_out))
		else $error("strobe fell before the byte was set up");

	chk_strobe_end: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_out_strobe_n) |-> $past(hrdy_s) ##1 o_port_bus_oe)
		else $error("strobe rose early or bus released too soon");

	chk_xoff_pause: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_port_bus_oe) |-> !$past(st_ff.xoff) && o_tx_ready)
		else $error("byte started while paused");

	chk_dir_follow: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_xcvr_dir |-> o_xcvr_drive_en && o_port_bus_oe)
		else $error("transceiver toward host without a driven byte");

	chk_mode_gate: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_msg_request_n) |-> $past(st_ff.par) && !$past(o_serial_sel))
		else $error("message started outside parallel mode");

endmodule : dph_port

//--- verif/dph_host.sv
// host model: drives the command and receive handshakes of the port
`timescale 1ns/1ns
module dph_host
(
	input  wire logic       i_clk,
	input  wire logic       i_accept_n,
	input  wire logic       i_strobe_n,
	input  wire logic [7:0] i_bus,
	output logic            o_pending_n,
	output logic            o_rx_ready_n,
	output logic      [7:0] o_bus
);
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		o_pending_n = 1'b1;
		o_rx_ready_n = 1'b1;
		o_bus = 8'h00;
	end
	// s picks the strobe, else accept; gives up after 40 edges
	task automatic wt(input bit s, input logic v, output bit ok);
		ok = 1'b0;
		repeat (40)
		begin
			@(posedge i_clk);
			#1;
			if ((s ? i_strobe_n : i_accept_n) === v)
			begin
				ok = 1'b1;
				break;
			end
		end
	endtask : wt
	////////////////////////////////////////////////////////////////////////
	task automatic send_cmd(input logic [7:0] b, output bit ok);
		bit k;
		@(negedge i_clk);
		o_pending_n = 1'b0;
		wt(1'b0, 1'b0, k);
		@(negedge i_clk);
		o_bus = b;
		@(negedge i_clk);
		o_pending_n = 1'b1;
		wt(1'b0, 1'b1, ok);
		ok = ok & k;
		// no pull on the bus: released lines show the inverse
		@(negedge i_clk);
		o_bus = ~b;
	endtask : send_cmd
	task automatic take(input int d, output logic [7:0] b, output bit ok);
		bit k;
		@(negedge i_clk);
		o_rx_ready_n = 1'b0;
		wt(1'b1, 1'b0, k);
		b = i_bus;
		repeat (d) @(negedge i_clk);
		@(negedge i_clk);
		o_rx_ready_n = 1'b1;
		wt(1'b1, 1'b1, ok);
		ok = ok & k;
	endtask : take
endmodule : dph_host

//--- verif/dph_port_tb_top.sv
// testbench: command, message, pacing and mode scenarios of the port
`timescale 1ns/1ns
module dph_port_tb_top
	import dph_pkg::*;
;
	logic             clk = 1'b0;
	logic             rstn, sel, crdy, txv, txl, oe, acc_n, stb_n;
	logic             req_n, den, dir, ser, cval, txr, paus, pend_n, rxr_n;
	logic [BUS_W-1:0] txd, bout, bin, hbus, cbyte;
	int               err_count, cmp_count, nval;
	assign bin = oe ? bout : hbus;
	dph_port u_dph_port (.i_clk(clk), .i_rstn(rstn), .i_io_port_select(sel),
		.i_cmd_pending_n(pend_n), .i_host_rx_ready_n(rxr_n),
		.i_port_bus_in(bin), .i_cmd_ready(crdy), .i_tx_valid(txv),
		.i_tx_data(txd), .i_tx_last(txl), .o_port_bus_out(bout),
		.o_port_bus_oe(oe), .o_cmd_accept_n(acc_n), .o_out_strobe_n(stb_n),
		.o_msg_request_n(req_n), .o_xcvr_drive_en(den), .o_xcvr_dir(dir),
		.o_serial_sel(ser), .o_cmd_byte(cbyte), .o_cmd_valid(cval),
		.o_tx_ready(txr), .o_xoff_paused(paus));
	dph_host u_dph_host (.i_clk(clk), .i_accept_n(acc_n), .i_strobe_n(stb_n),
		.i_bus(bin), .o_pending_n(pend_n), .o_rx_ready_n(rxr_n), .o_bus(hbus));
	always #5 clk = ~clk;
	// outputs are settled at the falling edge, away from their launch edge
	always @(negedge clk)
	begin
		if (cval === 1'b1)
			nval++;
		if (stb_n === 1'b0)
			chk(dir, 1'b1);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic cmd(input logic [7:0] b);
		bit ok;
		u_dph_host.send_cmd(b, ok);
		chk(ok, 1'b1);
		chk(cbyte, b);
	endtask : cmd
	task automatic put_msg(input int n, input logic [7:0] b0);
		bit ok;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			txv = 1'b1;
			txd = b0 + 8'(i);
			txl = (i == n - 1);
			ok = 1'b0;
			repeat (80)
			begin
				@(posedge clk);
				#1;
				if (txr === 1'b1)
				begin
					ok = 1'b1;
					break;
				end
			end
			chk(ok, 1'b1);
		end
		@(negedge clk);
		txv = 1'b0;
		txl = 1'b0;
	endtask : put_msg
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk({oe, acc_n, stb_n, req_n, den, dir, ser, paus}, 8'h78);
		$display("test reset done");
	endtask : t_reset
	task automatic t_cmd;
		// accept must wait for the user side, then back to back bytes
		crdy = 1'b0;
		fork
			cmd(8'ha5);
			begin
				repeat (8) @(negedge clk);
				chk(acc_n, 1'b1);
				crdy = 1'b1;
			end
		join
		cmd(8'h5a);
		// let the last valid pulse be tallied before reading the tally
		@(negedge clk);
		chk(nval[7:0], 8'h02);
		$display("test cmd done");
	endtask : t_cmd
	task automatic t_msg(input int n, input logic [7:0] b0, input int d);
		logic [7:0] g;
		bit         ok;
		fork
			put_msg(n, b0);
			for (int i = 0; i < n; i++)
			begin
				u_dph_host.take(d, g, ok);
				chk(ok, 1'b1);
				chk(g, b0 + 8'(i));
				if (i < n - 1)
					chk(req_n, 1'b0);
			end
		join
		repeat (4) @(negedge clk);
		chk({req_n, oe, dir}, 3'b100);
		$display("test msg done");
	endtask : t_msg
	task automatic t_pace;
		cmd(XOFF_CHAR);
		txv = 1'b1;
		txd = 8'h77;
		repeat (10) @(negedge clk);
		chk({req_n, paus}, 2'b11);
		cmd(XON_CHAR);
		chk(paus, 1'b0);
		chk(nval[7:0], 8'h02);
		t_msg(2, 8'h41, 0);
		$display("test pace done");
	endtask : t_pace
	task automatic t_mode;
		sel = 1'b0;
		fork
			cmd(8'h3c);
			begin
				repeat (10) @(negedge clk);
				chk({acc_n, ser, den}, 3'b110);
				sel = 1'b1;
			end
		join
		chk({ser, den}, 2'b01);
		$display("test mode done");
	endtask : t_mode
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#500000;
		err_count++;
		close_out();
	end
	initial
	begin
		rstn = 1'b0;
		sel = 1'b1;
		crdy = 1'b1;
		{txv, txl, txd} = 10'h000;
		err_count = 0;
		cmp_count = 0;
		nval = 0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_cmd();
		t_msg(3, 8'hc0, 0);
		t_msg(2, 8'h3e, 6);
		t_pace();
		t_mode();
		close_out();
	end
endmodule : dph_port_tb_top
